// ===== hdl/scan_pause_motor_current.sv
/*
  Pause/resume line gating and motor current control for the scan motion unit.
  Assumes pauseReq, resumeReq, lineStart, fullStep and stepActive come from
  same-clock logic; registers reached over a plain address/strobe port.
*/
// Decided for this implementation: the strobed register port.
// Function
// R1: Process 0-7 more lines after pause
// R2: Discard 0-7 lines after resume
// R3: Counts apply only when reverse steps zero
// R4: Software sets discard count equal pause count
// R5: Full current for first n full steps
// R6: Hold current 1-31 units, zero none
// R7: Hold count starts at stop, then off
`timescale 1ns/1ns
`default_nettype none
module scan_pause_motor_current
  import scan_motion_pkg::*;
#(
  parameter int UNIT_CYCLES = scan_motion_pkg::HOLD_UNIT_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdata,
  input  wire logic       pauseReq,
  input  wire logic       resumeReq,
  input  wire logic       lineStart,
  input  wire logic       fullStepMode,
  input  wire logic       moveStart,
  input  wire logic       fullStep,
  input  wire logic       stepActive,
  output logic            lineProcess,
  output logic            lineDiscard,
  output logic            maxCurrent,
  output logic            holdCurrent
);
  import scan_motion_pkg::*;

  logic [7:0]  lineCounts_reg;   // Pause and resume line counts
  logic [7:0]  motorCurrent_reg; // Kickstart steps and hold timeout
  logic [7:0]  reverseSteps_reg; // Reverse step count
  flow_state_e flow_reg;         // Line flow state
  logic [LINE_CNT_W-1:0] lineCnt_reg;  // Lines left in drain or discard
  logic [KICK_W-1:0]     kickCnt_reg;  // Full steps left at maximum current
  logic                  holdOn;       // Hold timer output

  // Field views
  logic [LINE_CNT_W-1:0] pauseLines;
  logic [LINE_CNT_W-1:0] resumeLines;
  logic [KICK_W-1:0]     kickSteps;
  logic [HOLD_W-1:0]     holdTimeout;
  logic                  countsApply;
  assign pauseLines  = lineCounts_reg[PAUSE_LINES_LSB +: LINE_CNT_W];
  assign resumeLines = lineCounts_reg[RESUME_LINES_LSB +: LINE_CNT_W];
  assign kickSteps   = motorCurrent_reg[KICK_STEPS_LSB +: KICK_W];
  assign holdTimeout = motorCurrent_reg[HOLD_TIMEOUT_LSB +: HOLD_W];
  // Line counts only matter when no reversal is programmed
  assign countsApply = (reverseSteps_reg == 8'h00);  // R3

  // Register writes; software keeps the two counts equal
  always_ff @(posedge clk) begin
    if (!nrst) begin
      lineCounts_reg   <= LINE_COUNTS_RST;
      motorCurrent_reg <= MOTOR_CURRENT_RST;
      reverseSteps_reg <= REVERSE_STEPS_RST;
    end else if (regWr) begin
      case (regAddr)
        LINE_COUNTS_OFS:   lineCounts_reg   <= regWdata;  // R4
        MOTOR_CURRENT_OFS: motorCurrent_reg <= regWdata;
        REVERSE_STEPS_OFS: reverseSteps_reg <= regWdata;
        default: begin
          // Unmapped writes are dropped
        end
      endcase
    end
  end

  // Read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (!nrst) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      case (regAddr)
        LINE_COUNTS_OFS:   regRdata <= lineCounts_reg;
        MOTOR_CURRENT_OFS: regRdata <= motorCurrent_reg;
        REVERSE_STEPS_OFS: regRdata <= reverseSteps_reg;
        MOTION_STATUS_OFS: regRdata <= {1'b0, holdCurrent, maxCurrent, lineCnt_reg, flow_reg};
        default:           regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end

  // Line flow: drain after pause, discard after resume
  always_ff @(posedge clk) begin
    if (!nrst) begin
      flow_reg    <= FLOW_RUN;
      lineCnt_reg <= '0;
    end else begin
      case (flow_reg)
        FLOW_RUN: begin
          if (pauseReq) begin
            // Without a count (reverse programmed or pause count zero) stop at once
            if (countsApply && pauseLines != '0) begin
              flow_reg    <= FLOW_DRAIN;  // R1
              lineCnt_reg <= pauseLines;
            end else begin
              flow_reg    <= FLOW_PAUSED;  // R3
            end
          end
        end
        FLOW_DRAIN: begin
          // Each line start uses up one of the extra lines
          if (lineStart) begin
            lineCnt_reg <= lineCnt_reg - 1'b1;
            if (lineCnt_reg == LINE_CNT_W'(1)) begin
              flow_reg <= FLOW_PAUSED;  // R1
            end
          end
        end
        FLOW_PAUSED: begin
          if (resumeReq) begin
            if (countsApply && resumeLines != '0) begin
              flow_reg    <= FLOW_DISCARD;  // R2
              lineCnt_reg <= resumeLines;
            end else begin
              flow_reg    <= FLOW_RUN;  // R3
            end
          end
        end
        FLOW_DISCARD: begin
          if (lineStart) begin
            lineCnt_reg <= lineCnt_reg - 1'b1;
            if (lineCnt_reg == LINE_CNT_W'(1)) begin
              flow_reg <= FLOW_RUN;  // R2
            end
          end
        end
        default: begin
          flow_reg <= FLOW_RUN;
        end
      endcase
    end
  end

  // Registered line gates derived from current state, one cycle behind it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      lineProcess <= 1'b0;
      lineDiscard <= 1'b0;
    end else begin
      // Processing while running or draining the extra lines
      lineProcess <= (flow_reg == FLOW_RUN) || (flow_reg == FLOW_DRAIN);  // R1
      lineDiscard <= (flow_reg == FLOW_DISCARD);  // R2
    end
  end

  // Kickstart: maximum current for first n full steps of a move
  always_ff @(posedge clk) begin
    if (!nrst) begin
      kickCnt_reg <= '0;
      maxCurrent  <= 1'b0;
    end else if (!fullStepMode) begin
      // Leaving full stepping mid-move must drop the boost at once
      maxCurrent  <= 1'b0;  // R5
      kickCnt_reg <= '0;
    end else if (moveStart) begin
      kickCnt_reg <= kickSteps;
      maxCurrent  <= (kickSteps != '0);  // R5
    end else if (fullStep && kickCnt_reg != '0) begin
      kickCnt_reg <= kickCnt_reg - 1'b1;
      // Drop after the n-th full step is taken
      if (kickCnt_reg == KICK_W'(1)) begin
        maxCurrent <= 1'b0;  // R5
      end
    end
  end

  // Hold current timer after the motor stops
  hold_current_timer #(
    .HOLD_W      (HOLD_W),
    .UNIT_CYCLES (UNIT_CYCLES)
  ) u_hold (
    .clk         (clk),
    .nrst        (nrst),
    .stepActive  (stepActive),
    .holdTimeout (holdTimeout),
    .holdOn      (holdOn)
  );

  // Registered copy keeps the output straight from a flip-flop
  always_ff @(posedge clk) begin
    if (!nrst) begin
      holdCurrent <= 1'b0;
    end else begin
      holdCurrent <= holdOn;  // R6
    end
  end
endmodule
`default_nettype wire

// ===== hdl/scan_motion_pkg.sv
/*
  Package for the pause/resume line counter and motor current block.
  Holds register offsets, field positions, reset values and the state enum.
  Assumes a plain address/strobe register port with 8-bit data.
*/
package scan_motion_pkg;
  // Register offsets (byte addresses on the plain register port)
  localparam logic [7:0] LINE_COUNTS_OFS    = 8'h53;  // Pause/resume line counts
  localparam logic [7:0] MOTOR_CURRENT_OFS  = 8'h54;  // Kickstart steps, hold timeout
  localparam logic [7:0] REVERSE_STEPS_OFS  = 8'h55;  // Programmed reverse step count
  localparam logic [7:0] MOTION_STATUS_OFS  = 8'h56;  // Live status, read only
  // Field positions of the line count register
  localparam int PAUSE_LINES_LSB   = 0;
  localparam int RESUME_LINES_LSB  = 3;
  // Field positions of the motor current register
  localparam int KICK_STEPS_LSB    = 0;
  localparam int HOLD_TIMEOUT_LSB  = 3;
  // Reset values
  localparam logic [7:0] LINE_COUNTS_RST   = 8'h00;
  localparam logic [7:0] MOTOR_CURRENT_RST = 8'h00;
  localparam logic [7:0] REVERSE_STEPS_RST = 8'h00;
  // Field widths
  localparam int LINE_CNT_W = 3;
  localparam int KICK_W     = 3;
  localparam int HOLD_W     = 5;
  // Hold time unit in clock cycles; base unit comes from outside, plain default
  localparam int HOLD_UNIT_CYCLES = 16;
  // Line flow states
  typedef enum logic [1:0] {
    FLOW_RUN     = 2'b00,
    FLOW_DRAIN   = 2'b01,
    FLOW_PAUSED  = 2'b10,
    FLOW_DISCARD = 2'b11
  } flow_state_e;
endpackage

// ===== hdl/hold_current_timer.sv
/*
  Hold current timer: counts time units after stepping stops.
  Assumes stepActive comes from logic on the same clock; the unit tick is counted here.
*/
`timescale 1ns/1ns
`default_nettype none
module hold_current_timer #(
  parameter int HOLD_W     = 5,
  parameter int UNIT_CYCLES = 16
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              stepActive,
  input  wire logic [HOLD_W-1:0] holdTimeout,
  output logic                   holdOn
);
  localparam int PRE_W = $clog2(UNIT_CYCLES + 1);
  logic [PRE_W-1:0]  prescale_reg;  // Cycles within one time unit
  logic [HOLD_W-1:0] units_reg;     // Time units still to hold
  logic              active_reg;    // Stepping seen last cycle

  // Track stepping and restart the count on its stop
  always_ff @(posedge clk) begin
    if (!nrst) begin
      active_reg   <= 1'b0;
      units_reg    <= '0;
      prescale_reg <= '0;
      holdOn       <= 1'b0;
    end else begin
      active_reg <= stepActive;
      if (stepActive) begin
        // Stepping: run current handled elsewhere, no hold
        holdOn       <= 1'b0;
        units_reg    <= '0;
        prescale_reg <= '0;
      end else if (active_reg) begin
        // Stop edge: load timeout, zero means no hold current
        units_reg    <= holdTimeout;  // R7
        prescale_reg <= PRE_W'(UNIT_CYCLES - 1);
        holdOn       <= (holdTimeout != '0);  // R6
      end else if (units_reg != '0) begin
        if (prescale_reg == '0) begin
          prescale_reg <= PRE_W'(UNIT_CYCLES - 1);
          units_reg    <= units_reg - 1'b1;
          // Remove winding current when the last unit ends
          if (units_reg == HOLD_W'(1)) begin
            holdOn <= 1'b0;  // R7
          end
        end else begin
          prescale_reg <= prescale_reg - 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== test/scan_chk.sv
/* Port checker for scan_pause_motor_current.
   Bound to the block; sees only its ports, one clock. */
`timescale 1ns/1ns
`default_nettype none
module scan_chk #(
  parameter int UNIT_CYCLES = 16
) (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [7:0] regRdata,
  input wire logic       pauseReq,
  input wire logic       resumeReq,
  input wire logic       lineStart,
  input wire logic       fullStepMode,
  input wire logic       moveStart,
  input wire logic       fullStep,
  input wire logic       stepActive,
  input wire logic       lineProcess,
  input wire logic       lineDiscard,
  input wire logic       maxCurrent,
  input wire logic       holdCurrent
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Flow levels lag their cause by two edges
  stop_cause_a: assert property ($fell(lineProcess) |-> $past(pauseReq, 2) || $past(lineStart, 2))
    else $error("line flow stopped without cause");
  drop_start_a: assert property ($rose(lineDiscard) |-> $past(resumeReq, 2))
    else $error("discard began without resume");
  drop_end_a: assert property ($fell(lineDiscard) |-> $past(lineStart, 2))
    else $error("discard ended without a line");
  flow_excl_a: assert property (!(lineProcess && lineDiscard))
    else $error("process and discard together");
  // Kickstart only in full stepping
  kick_mode_a: assert property (!fullStepMode |=> !maxCurrent)
    else $error("max current outside full stepping");
  kick_start_a: assert property ($rose(maxCurrent) |-> $past(moveStart) && $past(fullStepMode))
    else $error("max current without move start");
  // Hold only after stepping stops
  hold_idle_a: assert property (stepActive [*4] |-> !holdCurrent)
    else $error("hold current while stepping");
  hold_start_a: assert property ($rose(holdCurrent) |-> !$past(stepActive))
    else $error("hold began while stepping");
endmodule
bind scan_pause_motor_current scan_chk #(.UNIT_CYCLES(UNIT_CYCLES)) chk (.*);
`default_nettype wire

// ===== test/motor_drive_model.sv
/* Motor drive model: steps while run is high.
   Same clock and sync low reset as the block. */
`timescale 1ns/1ns
`default_nettype none
module motor_drive_model (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic run,
  output logic      stepActive,
  output logic      fullStep
);
  logic [1:0] phaseReg;  // Step spacing
  // One full step every fourth cycle, slow on purpose
  always_ff @(posedge clk) begin
    phaseReg   <= (nrst && run) ? phaseReg + 2'h1 : 2'h0;
    stepActive <= nrst && run;
    fullStep   <= nrst && run && phaseReg == 2'h3;
  end
endmodule
`default_nettype wire

// ===== test/scan_pause_motor_current_bench.sv
/* Bench: register and pulse tasks drive the block.
   Needs motor_drive_model; the checker is bound in. */
`timescale 1ns/1ns
`default_nettype none
module scan_pause_motor_current_bench;
  import scan_motion_pkg::*;
  localparam int U = 4;  // Short hold unit keeps runs brief
  logic clk, nrst, regWr, regRd, pauseReq, resumeReq, lineStart, fullStepMode, moveStart, run;
  logic fullStep, stepActive, lineProcess, lineDiscard, maxCurrent, holdCurrent;
  logic [7:0] regAddr, regWdata, regRdata;
  int failures = 0, num_checks = 0, cyc = 0, c, k, n, t;
  scan_pause_motor_current #(.UNIT_CYCLES(U)) dut (.*);
  motor_drive_model motor (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) failures++;
    if (cyc == 20000) give_verdict();
  end
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Write when w, else read and compare with d
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(posedge clk);
    regWr <= w;
    regRd <= !w;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    {regWr, regRd} <= 2'b00;
    #1 if (!w) chk("regRdata", regRdata, d);
  endtask
  // Mask bits: pause, resume, line, move start
  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    {pauseReq, resumeReq, lineStart, moveStart} <= m;
    @(posedge clk);
    {pauseReq, resumeReq, lineStart, moveStart} <= 4'h0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic give_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    {nrst, regWr, regRd, pauseReq, resumeReq, lineStart, fullStepMode, moveStart, run} = 9'h000;
    {regAddr, regWdata} = 16'h0000;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    acc(1'b0, LINE_COUNTS_OFS, LINE_COUNTS_RST);
    acc(1'b0, MOTOR_CURRENT_OFS, MOTOR_CURRENT_RST);
    acc(1'b0, REVERSE_STEPS_OFS, REVERSE_STEPS_RST);
    acc(1'b0, 8'h60, 8'h00);
    acc(1'b0, MOTION_STATUS_OFS, 8'h00);
    // Counts 0, 1, 3, 7: flow is {process, discard}
    for (n = 0; n < 8; n = n * 2 + 1) begin
      acc(1'b1, LINE_COUNTS_OFS, 8'(n * 9));
      acc(1'b0, LINE_COUNTS_OFS, 8'(n * 9));
      for (int p = 0; p < 2; p++) begin
        pulse(p ? 4'h4 : 4'h8);
        for (k = 0; k <= n; k++) begin
          if (k > 0) pulse(4'h2);
          chk("flow", {lineProcess, lineDiscard}, k < n ? (p ? 8'h01 : 8'h02) : (p ? 8'h02 : 8'h00));
        end
      end
    end
    // Reversal set: counts of 7 ignored
    acc(1'b1, REVERSE_STEPS_OFS, 8'h05);
    acc(1'b0, REVERSE_STEPS_OFS, 8'h05);
    pulse(4'h8);
    chk("flow", {lineProcess, lineDiscard}, 8'h00);
    pulse(4'h4);
    chk("flow", {lineProcess, lineDiscard}, 8'h02);
    acc(1'b1, REVERSE_STEPS_OFS, 8'h00);
    // Kick of 3 steps, then hold timeout 2 and 0
    fullStepMode <= 1'b1;
    for (t = 2; t >= 0; t -= 2) begin
      acc(1'b1, MOTOR_CURRENT_OFS, 8'(t * 8 + 3));
      pulse(4'h1);
      run <= 1'b1;
      c = 0;
      for (k = 0; k < 99 && maxCurrent === 1'b1; k++) begin
        // Settled step pulse, as the block samples it at the next edge
        if (fullStep === 1'b1) c++;
        @(posedge clk);
        #1;
      end
      chk("kickSteps", 8'(c), 8'h03);
      run <= 1'b0;
      c = 0;
      repeat (30) begin
        @(posedge clk);
        #1;
        if (holdCurrent === 1'b1) c++;
      end
      chk("holdOk", 8'(t ? (c > (t - 1) * U && c <= t * U + 2) : c == 0), 8'h01);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
